// File: sbtc_clk_source.sv
`timescale 1ns/1ps

// ****************************************************************
// Far-side clock source: a crystal or an external clock.
// ****************************************************************
module sbtc_clk_source #(
	parameter HALF_NS = 310
) (
	// Burst control from the bench.
	input wire go,
	input wire use_osc,
	// Clock lines into the block.
	output reg osc_pin,
	output reg ext_pin
);
	integer n_rise;
	initial begin
		osc_pin = 1'b0;
		ext_pin = 1'b0;
		n_rise = 0;
	end
	// Both lines stand low between bursts, so no stray edge is seen.
	always begin
		wait (go);
		#HALF_NS;
		if (use_osc)
			osc_pin = 1'b1;
		else
			ext_pin = 1'b1;
		n_rise = n_rise + 1;
		#HALF_NS;
		osc_pin = 1'b0;
		ext_pin = 1'b0;
	end
endmodule

// File: sbtc_defines.vh
`ifndef SBTC_DEFINES_VH
`define SBTC_DEFINES_VH

// ****************************************************************
// Register byte addresses on the AHB-Lite bus.
// ****************************************************************
`define SBTC_ADDR_COUNT_LOW 8'h00
`define SBTC_ADDR_COUNT_HIGH 8'h04
`define SBTC_ADDR_FLAG 8'h08
`define SBTC_ADDR_ENABLE 8'h0c
`define SBTC_ADDR_CONTROL 8'h10

// ****************************************************************
// Field positions in timer_one_control.
// ****************************************************************
`define SBTC_CTL_RUN 0
`define SBTC_CTL_CLKSRC 1
`define SBTC_CTL_SYNC_BYPASS 2
`define SBTC_CTL_OSC_EN 3
`define SBTC_CTL_PS_LO 4
`define SBTC_CTL_PS_HI 5
`define SBTC_CTL_MASK 8'h3f

// ****************************************************************
// Field positions in the flag and enable registers.
// ****************************************************************
`define SBTC_FLAG_OVF 0
`define SBTC_EN_OVF 0

// ****************************************************************
// Reset values and counter limits.
// ****************************************************************
`define SBTC_CTL_RESET 8'h00
`define SBTC_COUNT_ZERO 16'h0000
`define SBTC_COUNT_MAX 16'hffff

// ****************************************************************
// Bus encodings.
// ****************************************************************
`define SBTC_HTRANS_NONSEQ 2'h2
`define SBTC_HTRANS_SEQ 2'h3
`define SBTC_HRESP_OKAY 1'b0

`endif

// File: sbtc_sync.v
`timescale 1ns/1ps

// Two-stage synchroniser for a group of single-bit inputs.
module sbtc_sync #(
	parameter WIDTH = 1
) (
	// Clock, reset and enable.
	input wire sys_clk,
	input wire srst,
	input wire ce,
	// Asynchronous inputs and their synchronised copies.
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_reg;

	// The first stage feeds only the second stage.
	always @(posedge sys_clk) begin
		if (srst) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else if (ce) begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule

// File: sbtc_top.v
`timescale 1ns/1ps
`include "sbtc_defines.vh"

module sbtc_top #(
	parameter CYCLES_PER_INSTR = 4,
	parameter NEW_VARIANT = 1
) (
	// Clock, reset and clock enable.
	input wire sys_clk,
	input wire srst,
	input wire ce,
	// AHB-Lite slave port.
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	// External clock sources.
	input wire osc_input_pin,
	input wire ext_clock_pin,
	// Core state and capture/compare triggers, same clock domain.
	input wire sleep_mode,
	input wire capture_compare_unit_a,
	input wire capture_compare_unit_b,
	// Port pin direction handling.
	input wire [1:0] port_c_direction,
	output wire [1:0] port_c_dir_effective,
	// Oscillator power and interrupt request.
	output wire osc_power_on,
	output wire overflow_irq
);

	// ****************************************************************
	// Declarations.
	// ****************************************************************
	localparam PH_W = $clog2(CYCLES_PER_INSTR);
	// Last phase is worked out at full width, then cut to the counter's width.
	localparam [31:0] PH_LAST_FULL = CYCLES_PER_INSTR - 1;
	localparam [PH_W-1:0] PH_LAST = PH_LAST_FULL[PH_W-1:0];

	reg [7:0] control_reg;
	reg [15:0] count_reg;
	reg [15:0] count_next;
	reg overflow_flag_reg;
	reg overflow_irq_enable_reg;
	reg [PH_W-1:0] phase_reg;
	reg instr_level_reg;
	reg [2:0] prescale_reg;
	reg src_prev_reg;
	reg pre_sync1_reg;
	reg pre_sync2_reg;
	reg pre_sync3_reg;
	reg pre_bypass_prev_reg;
	reg wr_pend_reg;
	reg [7:0] wr_addr_reg;
	reg wrap_now;

	wire [1:0] pin_sync;
	wire counter_run;
	wire clock_source_select;
	wire sync_bypass;
	wire osc_enable;
	wire [1:0] prescale_sel;
	wire ext_level;
	wire src_level;
	wire src_rise;
	wire pre_out;
	wire sync_rise;
	wire bypass_rise;
	wire count_tick;
	wire addr_phase;
	wire ccp_clear;
	wire wr_low;
	wire wr_high;
	wire wr_flag;
	wire wr_enable;
	wire wr_control;

	assign counter_run = control_reg[`SBTC_CTL_RUN];
	assign clock_source_select = control_reg[`SBTC_CTL_CLKSRC];
	assign sync_bypass = control_reg[`SBTC_CTL_SYNC_BYPASS];
	assign osc_enable = control_reg[`SBTC_CTL_OSC_EN];
	assign prescale_sel = control_reg[`SBTC_CTL_PS_HI:`SBTC_CTL_PS_LO];

	// ****************************************************************
	// Pin synchronisers.
	// ****************************************************************

	// Both clock pins pass two flip-flops before any edge logic sees them.
	sbtc_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.ce(ce),
		.async_in({ext_clock_pin, osc_input_pin}),
		.sync_out(pin_sync)
	);

	// ****************************************************************
	// Clock source selection.
	// ****************************************************************

	// A stopped oscillator gives no edges, so osc_enable picks its pin over the external clock pin.
	assign ext_level = osc_enable ? pin_sync[0] : pin_sync[1];
	// Instruction-cycle level rises once every CYCLES_PER_INSTR clocks.
	assign src_level = clock_source_select ? ext_level : instr_level_reg;
	assign src_rise = src_level & ~src_prev_reg;

	// Phase counter that derives the instruction cycle from the system clock.
	always @(posedge sys_clk) begin
		if (srst) begin
			phase_reg <= {PH_W{1'b0}};
			instr_level_reg <= 1'b0;
			src_prev_reg <= 1'b0;
		end else if (ce) begin
			phase_reg <= (phase_reg == PH_LAST) ? {PH_W{1'b0}} : phase_reg + 1'b1;
			instr_level_reg <= (phase_reg == PH_LAST);
			src_prev_reg <= src_level;
		end
	end

	// ****************************************************************
	// Prescaler and synchroniser stage.
	// ****************************************************************

	// The prescaler counts every source edge and never sees sleep, so
	// edges are still divided while the synchroniser below is stopped.
	always @(posedge sys_clk) begin
		if (srst) begin
			prescale_reg <= 3'h0;
		end else if (ce && src_rise) begin
			prescale_reg <= prescale_reg + 3'h1;
		end
	end

	// Selected divider output: the raw level at 1:1, else one ripple bit.
	assign pre_out = (prescale_sel == 2'h0) ? src_level : prescale_reg[prescale_sel - 2'h1];

	// Synchronising stage behind the prescaler; it is shut off in sleep.
	always @(posedge sys_clk) begin
		if (srst) begin
			pre_sync1_reg <= 1'b0;
			pre_sync2_reg <= 1'b0;
			pre_sync3_reg <= 1'b0;
			pre_bypass_prev_reg <= 1'b0;
		end else if (ce) begin
			if (!sleep_mode) begin
				pre_sync1_reg <= pre_out;
				pre_sync2_reg <= pre_sync1_reg;
				pre_sync3_reg <= pre_sync2_reg;
			end
			pre_bypass_prev_reg <= pre_out;
		end
	end

	assign sync_rise = pre_sync2_reg & ~pre_sync3_reg & ~sleep_mode;
	assign bypass_rise = pre_out & ~pre_bypass_prev_reg;

	// The internal clock is always in step, so sync_bypass matters only externally.
	assign count_tick = counter_run &
		((clock_source_select && !sync_bypass) ? sync_rise : bypass_rise);

	// ****************************************************************
	// Bus slave.
	// ****************************************************************

	// Zero wait states and an OKAY answer on every access.
	assign hreadyout = 1'b1;
	assign hresp = `SBTC_HRESP_OKAY;
	assign addr_phase = hsel & hready & (htrans == `SBTC_HTRANS_NONSEQ || htrans == `SBTC_HTRANS_SEQ);

	// Write address is held for the data phase that follows.
	always @(posedge sys_clk) begin
		if (srst) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else if (ce && hready) begin
			wr_pend_reg <= addr_phase & hwrite;
			wr_addr_reg <= haddr;
		end
	end

	assign wr_low = wr_pend_reg && (wr_addr_reg == `SBTC_ADDR_COUNT_LOW);
	assign wr_high = wr_pend_reg && (wr_addr_reg == `SBTC_ADDR_COUNT_HIGH);
	assign wr_flag = wr_pend_reg && (wr_addr_reg == `SBTC_ADDR_FLAG);
	assign wr_enable = wr_pend_reg && (wr_addr_reg == `SBTC_ADDR_ENABLE);
	assign wr_control = wr_pend_reg && (wr_addr_reg == `SBTC_ADDR_CONTROL);

	// Read data is captured at the address phase from registered state,
	// so a byte read never sees a half-updated count.
	always @(posedge sys_clk) begin
		if (srst) begin
			hrdata <= 32'h00000000;
		end else if (ce && addr_phase && !hwrite) begin
			case (haddr)
				`SBTC_ADDR_COUNT_LOW: begin
					hrdata <= {24'h000000, count_reg[7:0]};
				end
				`SBTC_ADDR_COUNT_HIGH: begin
					hrdata <= {24'h000000, count_reg[15:8]};
				end
				`SBTC_ADDR_FLAG: begin
					hrdata <= {31'h00000000, overflow_flag_reg};
				end
				`SBTC_ADDR_ENABLE: begin
					hrdata <= {31'h00000000, overflow_irq_enable_reg};
				end
				`SBTC_ADDR_CONTROL: begin
					hrdata <= {24'h000000, control_reg};
				end
				default: begin
					hrdata <= 32'h00000000;
				end
			endcase
		end
	end

	// Control and enable registers; unimplemented control bits stay zero.
	always @(posedge sys_clk) begin
		if (srst) begin
			control_reg <= `SBTC_CTL_RESET;
			overflow_irq_enable_reg <= 1'b0;
		end else if (ce) begin
			if (wr_control) begin
				control_reg <= hwdata[7:0] & `SBTC_CTL_MASK;
			end
			if (wr_enable) begin
				overflow_irq_enable_reg <= hwdata[`SBTC_EN_OVF];
			end
		end
	end

	// ****************************************************************
	// Counter and overflow flag.
	// ****************************************************************
	assign ccp_clear = capture_compare_unit_a | capture_compare_unit_b;

	// Byte writes take priority, then the trigger clear, then counting.
	always @* begin
		count_next = count_reg;
		wrap_now = 1'b0;
		if (wr_low || wr_high) begin
			if (wr_low) begin
				count_next[7:0] = hwdata[7:0];
			end
			if (wr_high) begin
				count_next[15:8] = hwdata[7:0];
			end
		end else if (ccp_clear) begin
			count_next = `SBTC_COUNT_ZERO;
		end else if (count_tick) begin
			wrap_now = (count_reg == `SBTC_COUNT_MAX);
			count_next = count_reg + 16'h0001;
		end
	end

	// A wrap in the cycle of a software clear still sets the flag.
	always @(posedge sys_clk) begin
		if (srst) begin
			count_reg <= `SBTC_COUNT_ZERO;
			overflow_flag_reg <= 1'b0;
		end else if (ce) begin
			count_reg <= count_next;
			if (wrap_now) begin
				overflow_flag_reg <= 1'b1;
			end else if (wr_flag) begin
				overflow_flag_reg <= hwdata[`SBTC_FLAG_OVF];
			end
		end
	end

	// The request also serves as the wake signal during sleep.
	assign overflow_irq = overflow_flag_reg & overflow_irq_enable_reg;

	// ****************************************************************
	// Oscillator power and pin directions.
	// ****************************************************************
	assign osc_power_on = osc_enable;

	// Older variants leave pin zero to software, a 1 meaning input.
	assign port_c_dir_effective[1] = port_c_direction[1] | osc_enable;
	assign port_c_dir_effective[0] = port_c_direction[0] | (osc_enable && NEW_VARIANT != 0);

endmodule

// File: sbtc_top_bench.sv
`timescale 1ns/1ps
`include "sbtc_defines.vh"

// ****************************************************************
// Bench for the timer block.
// ****************************************************************
module sbtc_top_bench;
	reg sys_clk = 1'b0;
	reg srst = 1'b1;
	reg hwrite = 1'b0;
	reg sleep_mode = 1'b0;
	reg go = 1'b0;
	reg use_osc = 1'b0;
	reg [7:0] haddr = 8'h00;
	reg [1:0] htrans = 2'h0;
	reg [1:0] cc = 2'h0;
	reg [1:0] dir = 2'h0;
	reg [31:0] hwdata = 32'h0;
	reg [31:0] rd;
	integer n_mismatch = 0;
	integer num_checks = 0;
	integer i;
	integer n0;
	wire hreadyout;
	wire osc_pin;
	wire ext_pin;
	wire osc_on;
	wire irq;
	wire [31:0] hrdata;
	wire [1:0] dir_eff;
	// Select is held, so only htrans marks a transfer.
	sbtc_top sbtc_top_inst (.sys_clk(sys_clk), .srst(srst), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .osc_input_pin(osc_pin),
		.ext_clock_pin(ext_pin), .sleep_mode(sleep_mode), .capture_compare_unit_a(cc[0]),
		.capture_compare_unit_b(cc[1]), .port_c_direction(dir), .port_c_dir_effective(dir_eff),
		.osc_power_on(osc_on), .overflow_irq(irq));
	sbtc_clk_source sbtc_clk_source_inst (.go(go), .use_osc(use_osc), .osc_pin(osc_pin),
		.ext_pin(ext_pin));
	// System clock, 100 ns period.
	initial forever #50 sys_clk = ~sys_clk;
	// One bus transfer; the answer is awaited, never assumed.
	task ahb(input w, input [7:0] a, input [7:0] d);
		begin
			htrans <= `SBTC_HTRANS_NONSEQ;
			haddr <= a;
			hwrite <= w;
			@(posedge sys_clk);
			while (hreadyout !== 1'b1) @(posedge sys_clk);
			htrans <= 2'h0;
			hwdata <= {24'h0, d};
			@(posedge sys_clk);
			while (hreadyout !== 1'b1) @(posedge sys_clk);
			rd = hrdata;
		end
	endtask
	task chk(input string nm, input [31:0] exp, input [31:0] got);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("unexpected %s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	// Counts that depend on clock phase may land one either side.
	task chk_near(input string nm, input [7:0] exp, input [7:0] got);
		begin
			if (got === exp + 8'h01 || got === exp - 8'h01)
				chk(nm, got, got);
			else
				chk(nm, {24'h0, exp}, {24'h0, got});
		end
	endtask
	task rdchk(input [7:0] a, input [31:0] exp, input string nm);
		begin
			ahb(1'b0, a, 8'h00);
			chk(nm, exp, rd);
		end
	endtask
	task clear;
		begin
			ahb(1'b1, `SBTC_ADDR_COUNT_LOW, 8'h00);
			ahb(1'b1, `SBTC_ADDR_COUNT_HIGH, 8'h00);
		end
	endtask
	// Internal clock: 256 cycles give 256 / 4 / prescale counts.
	// The divider is picked while stopped, so a changed divider tap is no false edge.
	task int_case(input [1:0] ps);
		begin
			ahb(1'b1, `SBTC_ADDR_CONTROL, {2'b00, ps, 4'h0});
			clear;
			ahb(1'b1, `SBTC_ADDR_CONTROL, {2'b00, ps, 4'h1});
			repeat (256) @(posedge sys_clk);
			ahb(1'b1, `SBTC_ADDR_CONTROL, 8'h00);
			ahb(1'b0, `SBTC_ADDR_COUNT_LOW, 8'h00);
			chk_near("prescaled count", 8'd64 >> ps, rd[7:0]);
		end
	endtask
	// Ten external rising edges, then time for the synchroniser to drain.
	// The mode is set up stopped first, so edges of the old source drain uncounted.
	task ext_case(input [7:0] ctl, input osc, input slp, input [7:0] exp);
		begin
			use_osc = osc;
			ahb(1'b1, `SBTC_ADDR_CONTROL, ctl & 8'hfe);
			clear;
			sleep_mode <= slp;
			ahb(1'b1, `SBTC_ADDR_CONTROL, ctl);
			n0 = sbtc_clk_source_inst.n_rise;
			go = 1'b1;
			wait (sbtc_clk_source_inst.n_rise == n0 + 10);
			go = 1'b0;
			repeat (20) @(posedge sys_clk);
			ahb(1'b1, `SBTC_ADDR_CONTROL, 8'h00);
			sleep_mode <= 1'b0;
			rdchk(`SBTC_ADDR_COUNT_LOW, {24'h0, exp}, "external count");
		end
	endtask
	task results;
		begin
			if (n_mismatch == 0 && num_checks > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	// Cut a hang short well past the expected run of under two thousand cycles.
	initial begin
		#(100 * 20000);
		n_mismatch = n_mismatch + 1;
		results;
	end
	// Main sequence.
	initial begin
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		rdchk(`SBTC_ADDR_CONTROL, `SBTC_CTL_RESET, "control reset");
		rdchk(`SBTC_ADDR_FLAG, 32'h0, "flag reset");
		ahb(1'b1, 8'h14, 8'h5a);
		rdchk(8'h14, 32'h0, "unmapped");
		ahb(1'b1, `SBTC_ADDR_CONTROL, 8'hff);
		rdchk(`SBTC_ADDR_CONTROL, `SBTC_CTL_MASK, "control bits");
		chk("osc power", 32'h1, osc_on);
		chk("pins forced", 32'h3, dir_eff);
		dir <= 2'b10;
		ahb(1'b1, `SBTC_ADDR_CONTROL, 8'h00);
		@(posedge sys_clk);
		chk("osc power", 32'h0, osc_on);
		chk("pins own", 32'h2, dir_eff);
		ahb(1'b1, `SBTC_ADDR_COUNT_HIGH, 8'hff);
		ahb(1'b1, `SBTC_ADDR_COUNT_LOW, 8'hfe);
		rdchk(`SBTC_ADDR_COUNT_HIGH, 32'hff, "high byte");
		rdchk(`SBTC_ADDR_COUNT_LOW, 32'hfe, "low byte");
		ahb(1'b1, `SBTC_ADDR_CONTROL, 8'h01);
		repeat (16) @(posedge sys_clk);
		ahb(1'b1, `SBTC_ADDR_CONTROL, 8'h00);
		rdchk(`SBTC_ADDR_COUNT_HIGH, 32'h0, "high after wrap");
		rdchk(`SBTC_ADDR_FLAG, 32'h1, "flag set");
		ahb(1'b1, `SBTC_ADDR_ENABLE, 8'h01);
		@(posedge sys_clk);
		chk("request on", 32'h1, irq);
		ahb(1'b1, `SBTC_ADDR_ENABLE, 8'h00);
		@(posedge sys_clk);
		chk("request off", 32'h0, irq);
		rdchk(`SBTC_ADDR_FLAG, 32'h1, "flag held");
		ahb(1'b1, `SBTC_ADDR_FLAG, 8'h00);
		rdchk(`SBTC_ADDR_FLAG, 32'h0, "flag cleared");
		for (i = 0; i < 4; i = i + 1)
			int_case(i[1:0]);
		ext_case(8'h03, 1'b0, 1'b0, 8'd10);
		ext_case(8'h0b, 1'b1, 1'b0, 8'd10);
		ext_case(8'h03, 1'b1, 1'b0, 8'd0);
		ext_case(8'h13, 1'b0, 1'b0, 8'd5);
		ext_case(8'h03, 1'b0, 1'b1, 8'd0);
		ext_case(8'h07, 1'b0, 1'b1, 8'd10);
		for (i = 0; i < 2; i = i + 1) begin
			ahb(1'b1, `SBTC_ADDR_COUNT_LOW, 8'h55);
			cc <= 2'b01 << i;
			@(posedge sys_clk);
			cc <= 2'b00;
			rdchk(`SBTC_ADDR_COUNT_LOW, 32'h0, "cleared by trigger");
		end
		results;
	end
endmodule

// File: sbtc_top_checker.sv
`timescale 1ns/1ps
`include "sbtc_defines.vh"

// ****************************************************************
// Port checks for the timer block.
// ****************************************************************
module sbtc_top_checker #(
	parameter CYCLES_PER_INSTR = 4,
	parameter NEW_VARIANT = 1
) (
	// Clock, reset and enable.
	input wire sys_clk,
	input wire srst,
	input wire ce,
	// Bus.
	input wire hsel,
	input wire [7:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	// Pins and outputs.
	input wire [1:0] port_c_direction,
	input wire [1:0] port_c_dir_effective,
	input wire osc_power_on,
	input wire overflow_irq
);
	reg ph_wr;
	reg ph_rd;
	reg [7:0] ph_addr;
	reg [5:0] ctl_shadow;
	wire take = hsel && hready && htrans[1] && ce;
	wire ctl_wr = ph_wr && (ph_addr == `SBTC_ADDR_CONTROL);
	// Track the data phase, and keep our own copy of the control bits.
	always @(posedge sys_clk) begin
		if (srst) begin
			ph_wr <= 1'b0;
			ph_rd <= 1'b0;
			ph_addr <= 8'h00;
			ctl_shadow <= 6'h00;
		end else if (ce) begin
			ph_wr <= take && hwrite;
			ph_rd <= take && !hwrite;
			ph_addr <= haddr;
			if (ctl_wr)
				ctl_shadow <= hwdata[5:0];
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	sequence s_ctl_wr;
		ctl_wr;
	endsequence
	sequence s_en_off;
		ph_wr && ph_addr == `SBTC_ADDR_ENABLE && !hwdata[0];
	endsequence
	AST_BUS_OKAY: assert property (hreadyout && hresp == `SBTC_HRESP_OKAY)
		else $error("bus slave not ready or not okay");
	AST_UPPER_ZERO: assert property (ph_rd |-> hrdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	AST_CTL_READBACK: assert property (ph_rd && ph_addr == `SBTC_ADDR_CONTROL |->
		hrdata[7:0] == {2'b00, ctl_shadow}) else $error("control read back wrong");
	AST_OSC_POWER: assert property (s_ctl_wr |=> osc_power_on == ctl_shadow[3])
		else $error("oscillator power does not follow control");
	AST_OSC_STEADY: assert property (!$stable(osc_power_on) |-> $past(srst) || $past(ctl_wr))
		else $error("oscillator power changed without a write");
	AST_DIR_FORCED: assert property (osc_power_on |-> port_c_dir_effective ==
		(NEW_VARIANT ? 2'b11 : {1'b1, port_c_direction[0]})) else $error("pins not forced");
	AST_DIR_PASS: assert property (!osc_power_on |-> port_c_dir_effective == port_c_direction)
		else $error("pin directions not passed through");
	AST_IRQ_MASKED: assert property (s_en_off |=> !overflow_irq [*2])
		else $error("request seen while masked");
endmodule

bind sbtc_top sbtc_top_checker #(.CYCLES_PER_INSTR(CYCLES_PER_INSTR), .NEW_VARIANT(NEW_VARIANT))
	sbtc_top_checker_inst (.sys_clk(sys_clk), .srst(srst), .ce(ce), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .port_c_direction(port_c_direction),
	.port_c_dir_effective(port_c_dir_effective), .osc_power_on(osc_power_on),
	.overflow_irq(overflow_irq));
